/* File: rtl/swtl_pkg.sv */
package swtl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and bit timing

    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned BIT_WIN_US = 125;
    localparam int unsigned BIT_CYC = BIT_WIN_US * CLK_MHZ;
    localparam int unsigned POWERUP_MS = 75;
    localparam int unsigned POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////////
    // Duty cycles, high time in percent of the bit window

    localparam int unsigned PCT_FULL = 100;
    localparam int unsigned START_HIGH_PCT = 50;
    localparam int unsigned ONE_HIGH_PCT = 75;
    localparam int unsigned ZERO_HIGH_PCT = 25;

    ////////////////////////////////////////////////////////////////////////////
    // Update rates in millihertz and their periods in clock cycles

    localparam longint unsigned CLK_MILLI = 64'(CLK_MHZ) * 64'd1000000000;
    localparam longint unsigned RATE_250_MILLI = 250000;
    localparam longint unsigned RATE_10_MILLI = 10000;
    localparam longint unsigned RATE_1_MILLI = 1000;
    localparam longint unsigned RATE_0P1_MILLI = 100;
    localparam longint unsigned PERIOD_250_CYC = CLK_MILLI / RATE_250_MILLI;
    localparam longint unsigned PERIOD_10_CYC = CLK_MILLI / RATE_10_MILLI;
    localparam longint unsigned PERIOD_1_CYC = CLK_MILLI / RATE_1_MILLI;
    localparam longint unsigned PERIOD_0P1_CYC = CLK_MILLI / RATE_0P1_MILLI;

    localparam logic [1:0] RATE_SEL_250 = 2'h0;
    localparam logic [1:0] RATE_SEL_10 = 2'h1;
    localparam logic [1:0] RATE_SEL_1 = 2'h2;
    localparam logic [1:0] RATE_SEL_0P1 = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and packet layout

    localparam int unsigned TMR_W = 32;
    localparam int unsigned WIN_W = 16;
    localparam int unsigned DATA_W = 14;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned WORD_W = 9;
    localparam int unsigned HI14_W = 6;
    localparam int unsigned HI11_W = 3;
    localparam logic [3:0] IDX_START = 4'h0;
    localparam logic [3:0] IDX_PARITY = 4'h9;
    localparam int unsigned FIFO_DEPTH = 2;

    typedef enum logic [2:0]
    {
        SWTL_IDLE = 3'h1,
        SWTL_BIT = 3'h2,
        SWTL_STOP = 3'h4
    } swtl_state_t;

endpackage

/* File: rtl/swtl_stream_if.sv */
`timescale 1ns/1ns
interface swtl_stream_if;
    logic valid;
    logic ready;
    logic [swtl_pkg::DATA_W-1:0] data;

    modport src
    (
        output valid,
        output data,
        input ready
    );

    modport snk
    (
        input valid,
        input data,
        output ready
    );
endinterface

/* File: rtl/swtl_fifo.sv */
`timescale 1ns/1ns
// Two-entry buffer; the input ready is registered so no path runs through it
module swtl_fifo
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Streams
    swtl_stream_if.snk s_in,
    swtl_stream_if.src s_out
);

    logic [swtl_pkg::DATA_W-1:0] mem_reg [swtl_pkg::FIFO_DEPTH];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic ready_reg;
    logic push;
    logic pop;

    assign push = s_in.valid && ready_reg;
    assign pop = s_out.valid && s_out.ready;
    assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
    assign s_in.ready = ready_reg;
    assign s_out.valid = count_reg != 2'h0;
    assign s_out.data = mem_reg[rd_ptr_reg];

    always_ff @(posedge i_mclk)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= s_in.data;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            ready_reg <= 1'b0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg <= count_next;
            ready_reg <= count_next != 2'(swtl_pkg::FIFO_DEPTH);
        end
    end

endmodule

/* File: rtl/swtl_top.sv */
`timescale 1ns/1ns
module swtl_top
#(
    parameter int unsigned P_BIT_CYC = swtl_pkg::BIT_CYC,
    parameter int unsigned P_POWERUP_CYC = swtl_pkg::POWERUP_CYC,
    parameter longint unsigned P_PERIOD_250_CYC = swtl_pkg::PERIOD_250_CYC,
    parameter longint unsigned P_PERIOD_10_CYC = swtl_pkg::PERIOD_10_CYC,
    parameter longint unsigned P_PERIOD_1_CYC = swtl_pkg::PERIOD_1_CYC,
    parameter longint unsigned P_PERIOD_0P1_CYC = swtl_pkg::PERIOD_0P1_CYC
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Calibration straps
    input wire logic i_res14,
    input wire logic i_rate_cal,
    input wire logic [1:0] i_rate_sel,
    // Reading stream from the converter
    input wire logic i_temp_valid,
    input wire logic [swtl_pkg::DATA_W-1:0] i_temp_data,
    output logic o_temp_ready,
    // Single wire, push-pull
    output logic o_wire,
    output logic o_wire_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Timing constants

    localparam logic [swtl_pkg::WIN_W-1:0] WIN_LAST = swtl_pkg::WIN_W'(P_BIT_CYC - 1);
    localparam logic [swtl_pkg::WIN_W-1:0] START_LOW = swtl_pkg::WIN_W'(P_BIT_CYC
        * (swtl_pkg::PCT_FULL - swtl_pkg::START_HIGH_PCT) / swtl_pkg::PCT_FULL);
    localparam logic [swtl_pkg::WIN_W-1:0] ONE_LOW = swtl_pkg::WIN_W'(P_BIT_CYC
        * (swtl_pkg::PCT_FULL - swtl_pkg::ONE_HIGH_PCT) / swtl_pkg::PCT_FULL);
    localparam logic [swtl_pkg::WIN_W-1:0] ZERO_LOW = swtl_pkg::WIN_W'(P_BIT_CYC
        * (swtl_pkg::PCT_FULL - swtl_pkg::ZERO_HIGH_PCT) / swtl_pkg::PCT_FULL);
    localparam logic [swtl_pkg::TMR_W-1:0] PWRUP_LOAD = swtl_pkg::TMR_W'(P_POWERUP_CYC - 1);
    localparam logic [swtl_pkg::TMR_W-1:0] LOAD_250 = swtl_pkg::TMR_W'(P_PERIOD_250_CYC - 1);
    localparam logic [swtl_pkg::TMR_W-1:0] LOAD_10 = swtl_pkg::TMR_W'(P_PERIOD_10_CYC - 1);
    localparam logic [swtl_pkg::TMR_W-1:0] LOAD_1 = swtl_pkg::TMR_W'(P_PERIOD_1_CYC - 1);
    localparam logic [swtl_pkg::TMR_W-1:0] LOAD_0P1 = swtl_pkg::TMR_W'(P_PERIOD_0P1_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    swtl_pkg::swtl_state_t state_reg;
    swtl_pkg::swtl_state_t state_next;
    logic strap_done_reg;
    logic res14_reg;
    logic [1:0] rate_reg;
    logic [swtl_pkg::TMR_W-1:0] tmr_reg;
    logic [swtl_pkg::TMR_W-1:0] tmr_load;
    logic [swtl_pkg::WIN_W-1:0] win_reg;
    logic [swtl_pkg::WIN_W-1:0] low_len;
    logic [3:0] idx_reg;
    logic pkt2_reg;
    logic [swtl_pkg::WORD_W-1:0] word_reg;
    logic [swtl_pkg::DATA_W-1:0] value_reg;
    logic wire_reg;
    logic tick;
    logic win_last;
    logic start_frame;
    logic [swtl_pkg::DATA_W-1:0] frame_val;
    logic [swtl_pkg::BYTE_W-1:0] hi_byte;
    logic [swtl_pkg::BYTE_W-1:0] lo_byte;
    logic [swtl_pkg::WORD_W-1:0] hi_word;
    logic [swtl_pkg::WORD_W-1:0] lo_word;
    logic wire_next;
    logic in_idle;
    logic in_bit;
    logic at_start;
    logic at_parity;
    logic bit_end;
    logic pkt_end;
    logic sel_250;
    logic sel_10;
    logic sel_1;

    swtl_stream_if s_in ();
    swtl_stream_if s_out ();

    ////////////////////////////////////////////////////////////////////////////
    // Reading buffer; it drains only at frame start, so a slow update rate
    // fills it and the converter sees ready fall

    assign s_in.valid = i_temp_valid;
    assign s_in.data = i_temp_data;
    assign o_temp_ready = s_in.ready;

    swtl_fifo u_fifo
    (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .s_in(s_in),
        .s_out(s_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Straps are caught once, on the first edge after reset release

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            strap_done_reg <= 1'b0;
            res14_reg <= 1'b0;
            rate_reg <= swtl_pkg::RATE_SEL_10;
        end
        else if (!strap_done_reg)
        begin
            // Straps are never read again, so changing one needs a reset
            strap_done_reg <= 1'b1;
            res14_reg <= i_res14;
            if (i_rate_cal)
                rate_reg <= i_rate_sel;
            else if (i_res14)
                rate_reg <= swtl_pkg::RATE_SEL_1;
            else
                rate_reg <= swtl_pkg::RATE_SEL_10;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State and index decode

    assign in_idle = state_reg == swtl_pkg::SWTL_IDLE;
    assign in_bit = state_reg == swtl_pkg::SWTL_BIT;
    assign at_start = idx_reg == swtl_pkg::IDX_START;
    assign at_parity = idx_reg == swtl_pkg::IDX_PARITY;
    assign bit_end = in_bit && win_last;
    assign pkt_end = bit_end && at_parity;
    assign sel_250 = rate_reg == swtl_pkg::RATE_SEL_250;
    assign sel_10 = rate_reg == swtl_pkg::RATE_SEL_10;
    assign sel_1 = rate_reg == swtl_pkg::RATE_SEL_1;

    ////////////////////////////////////////////////////////////////////////////
    // Update timer; reset stands for power-up and arms the first-reading delay
    // A tick that lands mid-frame is dropped, so a period between half a frame
    // and a whole frame halves the update rate

    assign tmr_load = sel_250 ? LOAD_250 :
        sel_10 ? LOAD_10 :
        sel_1 ? LOAD_1 : LOAD_0P1;
    assign tick = tmr_reg == '0;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            tmr_reg <= PWRUP_LOAD;
        else if (tick)
            tmr_reg <= tmr_load;
        else
            tmr_reg <= tmr_reg - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame assembly; with no fresh reading the last one is sent again

    assign start_frame = tick && in_idle;
    assign s_out.ready = start_frame;
    assign frame_val = s_out.valid ? s_out.data : value_reg;
    assign hi_byte = res14_reg ?
        swtl_pkg::BYTE_W'(frame_val[swtl_pkg::DATA_W-1:swtl_pkg::BYTE_W]) :
        swtl_pkg::BYTE_W'(frame_val[swtl_pkg::BYTE_W+swtl_pkg::HI11_W-1:swtl_pkg::BYTE_W]);
    assign lo_byte = value_reg[swtl_pkg::BYTE_W-1:0];
    // Pad zeros above the upper bits leave the parity unchanged
    assign hi_word = {hi_byte, ^hi_byte};
    assign lo_word = {lo_byte, ^lo_byte};

    ////////////////////////////////////////////////////////////////////////////
    // Bit window timing

    assign win_last = win_reg == WIN_LAST;
    assign low_len = at_start ? START_LOW :
        (word_reg[swtl_pkg::WORD_W-1] ? ONE_LOW : ZERO_LOW);
    // Low from count zero gives the falling edge at each bit window's opening; the stop window stays high
    assign wire_next = in_bit ? (win_reg >= low_len) : 1'b1;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            swtl_pkg::SWTL_IDLE:
            begin
                if (start_frame)
                    state_next = swtl_pkg::SWTL_BIT;
            end
            swtl_pkg::SWTL_BIT:
            begin
                if (pkt_end)
                    state_next = pkt2_reg ? swtl_pkg::SWTL_IDLE : swtl_pkg::SWTL_STOP;
            end
            swtl_pkg::SWTL_STOP:
            begin
                if (win_last)
                    state_next = swtl_pkg::SWTL_BIT;
            end
            default:
            begin
                state_next = swtl_pkg::SWTL_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            state_reg <= swtl_pkg::SWTL_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge i_mclk)
    begin
        // Runs through the stop window as well; idle parks it at zero
        if (i_srst || in_idle || win_last)
            win_reg <= '0;
        else
            win_reg <= win_reg + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Packet sequencing: start, eight data bits MSB first, parity

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            idx_reg <= swtl_pkg::IDX_START;
            pkt2_reg <= 1'b0;
            word_reg <= '0;
            value_reg <= '0;
        end
        else if (start_frame)
        begin
            idx_reg <= swtl_pkg::IDX_START;
            pkt2_reg <= 1'b0;
            word_reg <= hi_word;
            value_reg <= frame_val;
        end
        else if (bit_end)
        begin
            if (at_parity)
            begin
                idx_reg <= swtl_pkg::IDX_START;
                pkt2_reg <= 1'b1;
                word_reg <= lo_word;
            end
            else
            begin
                idx_reg <= idx_reg + 1'b1;
                // The start window carries no data, so d7 stays on top through it
                if (!at_start)
                    word_reg <= {word_reg[swtl_pkg::WORD_W-2:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wire driver; push-pull, so the enable holds high after reset

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            wire_reg <= 1'b1;
            o_wire_oe <= 1'b0;
        end
        else
        begin
            wire_reg <= wire_next;
            o_wire_oe <= 1'b1;
        end
    end

    assign o_wire = wire_reg;

endmodule

/* File: tb/swtl_sva.sv */
`timescale 1ns/1ns
module swtl_sva
#(
    parameter int unsigned P_BIT_CYC = 40,
    parameter int unsigned P_POWERUP_CYC = 100
)
(
    // Clock, reset and straps
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_res14,
    input wire logic i_rate_cal,
    input wire logic [1:0] i_rate_sel,
    // Reading stream
    input wire logic i_temp_valid,
    input wire logic [swtl_pkg::DATA_W-1:0] i_temp_data,
    input wire logic o_temp_ready,
    // Line
    input wire logic o_wire,
    input wire logic o_wire_oe
);
    localparam int B = P_BIT_CYC;
    localparam int PU_LO = P_POWERUP_CYC - 2;
    localparam int PU_HI = P_POWERUP_CYC + 2;
    logic wire_reg;
    logic [31:0] low_reg;
    logic [31:0] gap_reg;
    logic [31:0] up_reg;
    logic [4:0] nf_reg;
    wire fall = wire_reg & ~o_wire;
    // A long quiet gap means the next fall opens a new frame
    wire newf = gap_reg > 32'(3 * B);

    always_ff @(posedge i_mclk)
    begin
        wire_reg <= o_wire;
        low_reg <= o_wire ? 32'h0 : low_reg + 32'h1;
        gap_reg <= i_srst ? 32'h8000_0000 : fall ? 32'h1 : gap_reg + 32'h1;
        up_reg <= i_srst ? 32'h0 : up_reg + 32'h1;
        nf_reg <= i_srst ? 5'h0 : !fall ? nf_reg : newf ? 5'h1 : nf_reg + 5'h1;
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    sequence s_release;
        $fell(i_srst);
    endsequence
    sequence s_first_fall;
        ##[PU_LO:PU_HI] !o_wire;
    endsequence

    chk_reset_state: assert property (disable iff (1'b0)
        i_srst |=> o_wire && !o_wire_oe && !o_temp_ready) else $error("reset outputs");
    chk_drive_on: assert property (s_release |=> o_wire_oe && o_temp_ready && o_wire)
        else $error("outputs after release");
    chk_drive_held: assert property (o_wire_oe |=> o_wire_oe) else $error("enable dropped");
    chk_powerup_quiet: assert property (up_reg < 32'(PU_LO) |-> o_wire)
        else $error("early frame");
    chk_first_frame: assert property (s_release |-> s_first_fall)
        else $error("late first frame");
    chk_bit_window: assert property (fall && !newf && nf_reg != 5'd10
        |-> gap_reg == 32'(B)) else $error("bit window length");
    chk_stop_window: assert property (fall && nf_reg == 5'd10
        |-> gap_reg == 32'(2 * B)) else $error("stop window length");
    chk_start_duty: assert property ($rose(o_wire) && (nf_reg == 5'd1 || nf_reg == 5'd11)
        |-> low_reg == 32'(B * 50 / 100)) else $error("start duty");
    chk_data_duty: assert property ($rose(o_wire) && nf_reg != 5'd1 && nf_reg != 5'd11
        |-> low_reg == 32'(B / 4) || low_reg == 32'(B * 3 / 4)) else $error("data duty");
    chk_frame_len: assert property (gap_reg == 32'(3 * B) && nf_reg != 5'd0
        |-> nf_reg == 5'd20) else $error("falls per frame");
    chk_gap_high: assert property (gap_reg > 32'(B) && gap_reg < 32'(2 * B)
        && (nf_reg == 5'd10 || nf_reg == 5'd20) |-> o_wire) else $error("line not high");
endmodule

bind swtl_top swtl_sva #(.P_BIT_CYC(P_BIT_CYC), .P_POWERUP_CYC(P_POWERUP_CYC)) u_sva
(
    .i_mclk(i_mclk), .i_srst(i_srst), .i_res14(i_res14), .i_rate_cal(i_rate_cal),
    .i_rate_sel(i_rate_sel), .i_temp_valid(i_temp_valid), .i_temp_data(i_temp_data),
    .o_temp_ready(o_temp_ready), .o_wire(o_wire), .o_wire_oe(o_wire_oe)
);

/* File: tb/swtl_rx_model.sv */
`timescale 1ns/1ns
module swtl_rx_model
#(
    parameter int unsigned P_BIT_CYC = 40
)
(
    // Clock, line and parity enable
    input wire logic i_mclk,
    input wire logic i_line,
    input wire logic i_par_en,
    // Decoded reading
    output logic o_valid,
    output logic [15:0] o_word,
    output logic o_perr
);
    localparam int LIM = 4 * P_BIT_CYC;
    logic [7:0] b1;
    logic [7:0] b2;
    logic e1;
    logic e2;
    bit ok;

    // Polled every clock, far above sixteen samples a bit
    task automatic wait_lvl(input logic lvl, input int lim, output bit ok);
        int n;
        n = 0;
        while (i_line !== lvl && n < lim)
        begin
            @(posedge i_mclk);
            n++;
        end
        ok = n < lim;
    endtask

    task automatic get_byte(input int lim, output logic [7:0] b, output logic e, output bit ok);
        int t;
        logic p;
        b = 8'h0;
        p = 1'b0;
        t = 0;
        wait_lvl(1'b1, lim, ok);
        if (ok)
            wait_lvl(1'b0, lim, ok);
        while (ok && i_line === 1'b0 && t < LIM)
        begin
            @(posedge i_mclk);
            t++;
        end
        for (int i = 0; i < 9 && ok; i++)
        begin
            wait_lvl(1'b1, LIM, ok);
            if (ok)
                wait_lvl(1'b0, LIM, ok);
            repeat (t) @(posedge i_mclk);
            if (i < 8)
                b = {b[6:0], i_line};
            else
                p = i_line;
        end
        e = i_par_en & (^{b, p});
    endtask

    initial
    begin
        o_valid = 1'b0;
        o_word = 16'h0;
        o_perr = 1'b0;
        forever
        begin
            get_byte(1000000, b1, e1, ok);
            if (ok)
                get_byte(LIM, b2, e2, ok);
            @(negedge i_mclk);
            o_valid = ok;
            o_word = {b1, b2};
            o_perr = e1 | e2;
            @(negedge i_mclk);
            o_valid = 1'b0;
        end
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
    localparam int BIT = 40;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic i_res14 = 1'b0;
    logic i_rate_cal = 1'b0;
    logic [1:0] i_rate_sel = 2'h0;
    logic i_temp_valid = 1'b0;
    logic [swtl_pkg::DATA_W-1:0] i_temp_data = '0;
    logic o_temp_ready, o_wire, o_wire_oe, line, rx_valid, rx_perr;
    logic [15:0] rx_word;
    logic par_en = 1'b1;
    logic [31:0] seed = 32'ha699133e;
    logic [13:0] last;
    logic [13:0] buf_q[$];
    logic [15:0] exp_q[$];
    logic [15:0] mask;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int quiet = 0;
    int t_last = -1;
    int period;

    always #4 i_mclk = ~i_mclk;
    // Bench pull-up holds the line while the device is in reset
    assign line = o_wire_oe ? o_wire : 1'b1;

    swtl_top #(.P_BIT_CYC(BIT), .P_POWERUP_CYC(200), .P_PERIOD_250_CYC(1000),
        .P_PERIOD_10_CYC(1050), .P_PERIOD_1_CYC(1100), .P_PERIOD_0P1_CYC(1150)) dut
    (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_res14(i_res14), .i_rate_cal(i_rate_cal),
        .i_rate_sel(i_rate_sel), .i_temp_valid(i_temp_valid), .i_temp_data(i_temp_data),
        .o_temp_ready(o_temp_ready), .o_wire(o_wire), .o_wire_oe(o_wire_oe)
    );
    swtl_rx_model #(.P_BIT_CYC(BIT)) rx
    (
        .i_mclk(i_mclk), .i_line(line), .i_par_en(par_en), .o_valid(rx_valid),
        .o_word(rx_word), .o_perr(rx_perr)
    );

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [13:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[13:0];
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Offer is held while refused; the entry counts once ready is seen
    task automatic offer(input logic [13:0] v);
        int n;
        n = 0;
        @(negedge i_mclk);
        i_temp_valid = 1'b1;
        i_temp_data = v;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (o_temp_ready !== 1'b1 && n < 3000);
        if (o_temp_ready !== 1'b1)
        begin
            failures++;
            end_of_test();
        end
        buf_q.push_back(v);
        @(negedge i_mclk);
        i_temp_valid = 1'b0;
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (rx_valid !== 1'b1 && n < 3000);
        if (rx_valid !== 1'b1)
        begin
            failures++;
            end_of_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reference: the value sent is fixed at the frame start
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc > 45000)
        begin
            failures++;
            end_of_test();
        end
        if (i_srst === 1'b1)
        begin
            buf_q.delete();
            exp_q.delete();
            last = 14'h0;
            t_last = -1;
        end
        else if (line === 1'b0 && quiet > 2 * BIT)
        begin
            if (buf_q.size() > 0)
                last = buf_q.pop_front();
            exp_q.push_back(16'(last) & mask);
            if (t_last >= 0)
                check("period", 32'(cyc - t_last), 32'(period));
            t_last = cyc;
        end
        quiet = (line === 1'b1 && i_srst === 1'b0) ? quiet + 1 : 0;
        if (rx_valid === 1'b1)
        begin
            check("word", 32'(rx_word), 32'(exp_q.pop_front()));
            check("parity", 32'(rx_perr), 32'h0);
        end
    end

    initial
    begin
        for (int k = 0; k < 6; k++)
        begin
            if (k == 5)
            begin
                // Supply cut in mid-frame aborts the reading
                @(negedge line);
                repeat (300) @(negedge i_mclk);
            end
            @(negedge i_mclk);
            i_srst = 1'b1;
            i_res14 = (k == 0) || (k > 1 && rnd() > 14'h1fff);
            i_rate_cal = k > 1;
            par_en = k != 3;
            i_rate_sel = 2'(k - 2);
            period = (k == 0) ? 1100 : (k == 1) ? 1050 : 1000 + 50 * (k - 2);
            mask = i_res14 ? 16'h3fff : 16'h07ff;
            repeat (3) @(negedge i_mclk);
            i_srst = 1'b0;
            if (k != 1)
            begin
                offer(rnd());
                offer(rnd());
                @(negedge i_mclk);
                check("ready", 32'(o_temp_ready), 32'h0);
                offer(rnd());
            end
            for (int f = 0; f < 4; f++)
            begin
                wait_valid();
                if (f == 0 && k == 1)
                    offer(rnd());
            end
        end
        end_of_test();
    end
endmodule
